// File: design/nic_power_and_pnp_port_regs.sv
// Notes on behaviour
// - Sleep forces LEDs off except coax LED.
// - Sleep resets zero, writable only in mode 11.
// - Power-down turns off network interface entirely.
// - Power-down: LEDs high, coax LED driven low.
// - Halted mode stops clock; in group one only halt register reachable.
// - Power-down loads from EEPROM, writable in mode 11.
// - Inactive bit reads inverse of activate bit.
// - Inactive: ignore boot ROM and group one except the halt register.
// - Full decode compares 16 bits, else ten.
// - Full-decode bit read-only, from EEPROM byte.
// - Offset 08 reads backup of card number.
// - Halt writes ignored unless power-down set.
// - 52 selects running, 48 halted, others ignored.
// - Offset 0B mirrors eight interrupt request lines.
// - Flash unlocked by 57 then A8 only.
// - Flash write commands ignored while locked.
// - Decode index, write and relocatable read ports.
// - Index kept for any number of accesses.
// - Index port also takes initiation key.
// - Undefined Plug and Play registers read zero.
// - Index 00 sets read port bits 9..2.
`timescale 1ns/10ps
`include "nic_power_regs.svh"

module nic_power_and_pnp_port_regs #(
    parameter logic [15:0] GROUP_BASE = 16'h0300
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire nic_power_pkg::io_req_t ioReq,
    input  wire logic [1:0]             eepromMode,
    input  wire logic                   eepromPowerDown,
    input  wire logic                   eepromFullDecode,
    input  wire logic [7:0]             irqLines,
    input  wire logic [2:0]             ledIn,
    input  wire logic                   coaxLedIn,
    input  wire logic                   bootRomReadReq,
    input  wire logic                   flashWriteReq,
    output logic [7:0]                  ioRdata,
    output logic                        ioRdataValid,
    output logic [2:0]                  ledOut,
    output logic                        coaxLed,
    output logic                        netEnable,
    output logic                        clockRun,
    output logic                        bootRomSelect,
    output logic                        flashWriteGo,
    output logic                        flashWriteEnabled
);
    import nic_power_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic         sleepBit;
    logic         powerDown;
    logic         fullDecode;
    pd_mode_t     pdMode;
    flash_state_t flashState;
    logic [7:0]   pnpIndex;
    logic [7:0]   readPortSel;
    logic [7:0]   cardSelectNumber;
    logic [7:0]   cardNumberBackup;
    logic         activateBit;
    logic [7:0]   keyLfsr;
    logic [4:0]   keyCount;
    logic         keyDone;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic groupHit(input logic [15:0] a, input logic full, input logic [3:0] off);
        logic [15:0] target;
        target = GROUP_BASE + {12'h000, off};
        groupHit = full ? (a == target) : (a[9:0] == target[9:0]);
    endfunction : groupHit

    function automatic logic [7:0] lfsrStep(input logic [7:0] v);
        lfsrStep = {v[1] ^ v[0], v[7:1]};
    endfunction : lfsrStep

    logic modeOpen;
    logic halted;
    logic groupOpen;
    logic hitConfig3;
    logic hitBackup;
    logic hitHalt;
    logic hitIrq;
    logic hitUnlock;
    logic hitDecode;
    logic hitIndex;
    logic hitWrite;
    logic hitRead;

    always_comb begin
        modeOpen   = (eepromMode == 2'b11);
        halted     = powerDown && (pdMode == PD_HALTED);
        groupOpen  = activateBit && !halted;
        hitConfig3 = groupHit(ioReq.addr, fullDecode, `OFF_POWER_LED_CONFIG) && groupOpen;
        hitBackup  = groupHit(ioReq.addr, fullDecode, `OFF_CARD_BACKUP) && groupOpen;
        hitHalt    = groupHit(ioReq.addr, fullDecode, `OFF_CLOCK_HALT);
        hitIrq     = groupHit(ioReq.addr, fullDecode, `OFF_IRQ_MIRROR) && groupOpen;
        hitUnlock  = groupHit(ioReq.addr, fullDecode, `OFF_FLASH_UNLOCK) && groupOpen;
        hitDecode  = groupHit(ioReq.addr, fullDecode, `OFF_DECODE_CONFIG) && groupOpen;
        hitIndex   = (ioReq.addr[11:0] == `PORT_PNP_INDEX);
        hitWrite   = (ioReq.addr[11:0] == `PORT_PNP_WRITE);
        hitRead    = keyDone && (ioReq.addr[9:0] == {readPortSel, 2'b11});
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power and LED configuration.

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleepBit <= 1'b0;
        end else if (ioReq.wr && hitConfig3 && modeOpen) begin
            sleepBit <= ioReq.wdata[`BIT_SLEEP];
        end
    end

    // The straps are caught while reset is held, so they settle before release.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerDown  <= eepromPowerDown;
            fullDecode <= eepromFullDecode;
        end else if (ioReq.wr && hitConfig3 && modeOpen) begin
            powerDown <= ioReq.wdata[`BIT_POWER_DOWN];
        end
    end

    // Halt writes also reach the device while it is inactive, so it can always be woken.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pdMode <= PD_RUNNING;
        end else if (!powerDown) begin
            pdMode <= PD_RUNNING;
        end else if (ioReq.wr && hitHalt) begin
            case (ioReq.wdata)
                `HALT_CMD_RUNNING: pdMode <= PD_RUNNING;
                `HALT_CMD_HALTED:  pdMode <= PD_HALTED;
                default:           pdMode <= pdMode;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ledOut    <= 3'b111;
            coaxLed   <= 1'b0;
            netEnable <= 1'b0;
            clockRun  <= 1'b1;
        end else begin
            ledOut    <= (sleepBit || powerDown) ? 3'b111 : ledIn;
            coaxLed   <= powerDown ? 1'b0 : coaxLedIn;
            netEnable <= !powerDown;
            clockRun  <= !halted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash write unlock.

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flashState <= FL_LOCKED;
        end else if (ioReq.wr && hitUnlock && modeOpen) begin
            case (flashState)
                FL_FIRST: flashState <= (ioReq.wdata == `UNLOCK_SECOND) ? FL_OPEN :
                                        (ioReq.wdata == `UNLOCK_FIRST) ? FL_FIRST : FL_LOCKED;
                default:  flashState <= (ioReq.wdata == `UNLOCK_FIRST) ? FL_FIRST : FL_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flashWriteEnabled <= 1'b0;
            flashWriteGo      <= 1'b0;
            bootRomSelect     <= 1'b0;
        end else begin
            flashWriteEnabled <= (flashState == FL_OPEN);
            flashWriteGo      <= flashWriteReq && (flashState == FL_OPEN);
            bootRomSelect     <= bootRomReadReq && activateBit && !halted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Plug and Play ports.

    // The key generator restarts whenever an index write breaks the sequence.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            keyLfsr  <= `KEY_SEED;
            keyCount <= 5'd0;
            keyDone  <= 1'b0;
        end else if (ioReq.wr && hitIndex && !keyDone) begin
            if (ioReq.wdata == keyLfsr) begin
                keyLfsr  <= lfsrStep(keyLfsr);
                keyCount <= keyCount + 5'd1;
                keyDone  <= (keyCount == `KEY_LENGTH);
            end else begin
                keyLfsr  <= `KEY_SEED;
                keyCount <= 5'd0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pnpIndex <= 8'h00;
        end else if (ioReq.wr && hitIndex) begin
            pnpIndex <= ioReq.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            readPortSel      <= `RST_READ_PORT_SEL;
            cardSelectNumber <= `RST_CARD_SELECT;
            cardNumberBackup <= `RST_CARD_SELECT;
            activateBit      <= 1'b0;
        end else if (ioReq.wr && hitWrite && keyDone) begin
            case (pnpIndex)
                `IDX_SET_READ_PORT: readPortSel <= ioReq.wdata;
                `IDX_CARD_SELECT: begin
                    cardSelectNumber <= ioReq.wdata;
                    cardNumberBackup <= ioReq.wdata;
                end
                `IDX_ACTIVATE: activateBit <= ioReq.wdata[0];
                default: activateBit <= activateBit;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data.

    logic [7:0] next_ioRdata;
    logic       next_ioRdataValid;

    always_comb begin
        next_ioRdata      = 8'h00;
        next_ioRdataValid = ioReq.rd;
        if (hitRead) begin
            case (pnpIndex)
                `IDX_CARD_SELECT: next_ioRdata = cardSelectNumber;
                `IDX_ACTIVATE:    next_ioRdata = {7'h00, activateBit};
                default:          next_ioRdata = 8'h00;
            endcase
        end else if (hitConfig3) begin
            next_ioRdata = {5'h00, sleepBit, powerDown, !activateBit};
        end else if (hitBackup) begin
            next_ioRdata = cardNumberBackup;
        end else if (hitIrq) begin
            next_ioRdata = irqLines;
        end else if (hitDecode) begin
            next_ioRdata = {7'h00, fullDecode};
        end else begin
            next_ioRdataValid = 1'b0;
        end
        if (!ioReq.rd) begin
            next_ioRdataValid = 1'b0;
            next_ioRdata      = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ioRdata      <= 8'h00;
            ioRdataValid <= 1'b0;
        end else begin
            ioRdata      <= next_ioRdata;
            ioRdataValid <= next_ioRdataValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sleep_leds_a: assert property (@(posedge clk_sys) disable iff (rst)
        sleepBit |=> ledOut == 3'b111)
        else $error("Sleep did not force LEDs off.");

    sleep_locked_a: assert property (@(posedge clk_sys) disable iff (rst)
        (eepromMode != 2'b11) |=> $stable(sleepBit))
        else $error("Sleep bit changed outside mode 11.");

    pd_network_a: assert property (@(posedge clk_sys) disable iff (rst)
        powerDown |=> !netEnable && !coaxLed)
        else $error("Power-down left network or coax LED on.");

    pd_leds_a: assert property (@(posedge clk_sys) disable iff (rst)
        powerDown |=> ledOut == 3'b111)
        else $error("Power-down did not force LEDs off.");

    halt_clock_a: assert property (@(posedge clk_sys) disable iff (rst)
        (powerDown && pdMode == PD_HALTED) |=> !clockRun)
        else $error("Clock kept running in halted mode.");

    halt_ignored_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!powerDown && ioReq.wr && hitHalt) |=> pdMode == PD_RUNNING)
        else $error("Halt write took effect outside power-down.");

    halt_select_a: assert property (@(posedge clk_sys) disable iff (rst)
        (powerDown && ioReq.wr && hitHalt && ioReq.wdata == `HALT_CMD_HALTED && !(ioReq.wr && hitConfig3))
        |=> pdMode == PD_HALTED)
        else $error("Halted-mode command not taken.");

    inactive_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ioReq.rd && hitConfig3 && !hitRead) |=> ioRdataValid && ioRdata[`BIT_INACTIVE] == !$past(activateBit))
        else $error("Inactive bit is not the inverse of activate.");

    irq_mirror_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ioReq.rd && hitIrq && !hitRead && !hitConfig3 && !hitBackup) |=> ioRdata == $past(irqLines))
        else $error("Interrupt mirror read wrong value.");

    flash_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
        flashWriteGo |-> $past(flashState) == FL_OPEN)
        else $error("Flash write passed while locked.");

    flash_seq_a: assert property (@(posedge clk_sys) disable iff (rst)
        (flashState == FL_LOCKED) ##1 (flashState == FL_OPEN) |-> 1'b0)
        else $error("Flash opened without first unlock byte.");

    inactive_rom_a: assert property (@(posedge clk_sys) disable iff (rst)
        !activateBit |=> !bootRomSelect)
        else $error("Boot ROM selected while inactive.");

    decode_fixed_a: assert property (@(posedge clk_sys) disable iff (rst)
        $stable(fullDecode))
        else $error("Full-decode bit changed outside reset.");

    full_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
        (fullDecode && ioReq.addr[15:10] != GROUP_BASE[15:10])
        |-> !(hitConfig3 || hitBackup || hitHalt || hitIrq || hitUnlock || hitDecode))
        else $error("Full decode accepted a mismatched upper address.");

    halted_idle_cover: cover property (@(posedge clk_sys) disable iff (rst)
        powerDown && pdMode == PD_HALTED && !activateBit);

    full_decode_cover: cover property (@(posedge clk_sys) disable iff (rst)
        fullDecode && ioRdataValid);

    unlock_cover: cover property (@(posedge clk_sys) disable iff (rst)
        flashState == FL_FIRST ##1 flashState == FL_OPEN);

    halted_cover: cover property (@(posedge clk_sys) disable iff (rst)
        !clockRun ##[1:20] clockRun);

    key_cover: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(keyDone));

endmodule : nic_power_and_pnp_port_regs

// File: design/nic_power_pkg.sv
package nic_power_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } io_req_t;

    typedef enum logic [0:0] {
        PD_RUNNING = 1'b0,
        PD_HALTED  = 1'b1
    } pd_mode_t;

    typedef enum logic [1:0] {
        FL_LOCKED = 2'b00,
        FL_FIRST  = 2'b01,
        FL_OPEN   = 2'b10
    } flash_state_t;

endpackage : nic_power_pkg

// File: design/nic_power_regs.svh
`ifndef NIC_POWER_REGS_SVH
`define NIC_POWER_REGS_SVH

// Register offsets inside the first register group.
`define OFF_POWER_LED_CONFIG   4'h6
`define OFF_CARD_BACKUP        4'h8
`define OFF_CLOCK_HALT         4'h9
`define OFF_IRQ_MIRROR         4'hb
`define OFF_FLASH_UNLOCK       4'hc
`define OFF_DECODE_CONFIG      4'hd

// Auto-configuration port addresses.
`define PORT_PNP_INDEX         12'h279
`define PORT_PNP_WRITE         12'ha79

// Plug and Play register indices.
`define IDX_SET_READ_PORT      8'h00
`define IDX_CARD_SELECT        8'h06
`define IDX_ACTIVATE           8'h30

// Field positions of the power and LED configuration register.
`define BIT_SLEEP              2
`define BIT_POWER_DOWN         1
`define BIT_INACTIVE           0

// Command values.
`define HALT_CMD_RUNNING       8'h52
`define HALT_CMD_HALTED        8'h48
`define UNLOCK_FIRST           8'h57
`define UNLOCK_SECOND          8'ha8

// Initiation key generator.
`define KEY_SEED               8'h6a
`define KEY_LENGTH             5'd31

// Reset values.
`define RST_CARD_SELECT        8'h00
`define RST_READ_PORT_SEL      8'h00

`endif

// File: dv/isa_host_model.sv
`timescale 1ns/10ps
`include "nic_power_regs.svh"
////////////////////////////////////////////////////////////////
module isa_host_model #(
    parameter logic [15:0] GROUP_BASE = 16'h0300
) (
    input  wire logic              clk_sys,
    output nic_power_pkg::io_req_t ioReq,
    input  wire logic [7:0]        ioRdata,
    input  wire logic              ioRdataValid
);
    import nic_power_pkg::*;

    initial ioReq = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

    // Released lines show the inverse of their last value so stale data never passes.
    task automatic ioWrite(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        ioReq.addr = a;
        ioReq.wdata = d;
        ioReq.wr = 1'b1;
        @(negedge clk_sys);
        ioReq.wr = 1'b0;
        ioReq.addr = ~a;
        ioReq.wdata = ~d;
    endtask : ioWrite

    task automatic ioRead(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        ioReq.addr = a;
        ioReq.rd = 1'b1;
        @(negedge clk_sys);
        ioReq.rd = 1'b0;
        ioReq.addr = ~a;
        d = ioRdata;
        v = ioRdataValid;
    endtask : ioRead

    task automatic pnpWrite(input logic [7:0] idx, input logic [7:0] d);
        ioWrite({4'h0, `PORT_PNP_INDEX}, idx);
        ioWrite({4'h0, `PORT_PNP_WRITE}, d);
    endtask : pnpWrite

    task automatic sendKey();
        logic [7:0] k;
        k = `KEY_SEED;
        repeat (32) begin
            ioWrite({4'h0, `PORT_PNP_INDEX}, k);
            k = {k[1] ^ k[0], k[7:1]};
        end
    endtask : sendKey

    task automatic unlockFlash();
        ioWrite(GROUP_BASE + 16'h000c, `UNLOCK_FIRST);
        ioWrite(GROUP_BASE + 16'h000c, `UNLOCK_SECOND);
    endtask : unlockFlash
endmodule : isa_host_model

// File: dv/nic_power_and_pnp_port_regs_tb.sv
`timescale 1ns/10ps
`include "nic_power_regs.svh"
////////////////////////////////////////////////////////////////
module nic_power_and_pnp_port_regs_tb;
    import nic_power_pkg::*;
    localparam logic [15:0] BASE  = 16'h0300;
    localparam logic [15:0] RPORT = 16'h0203;
    logic       clk_sys, rst, eepromPowerDown, eepromFullDecode, coaxLedIn, bootRomReadReq, flashWriteReq;
    logic       ioRdataValid, coaxLed, netEnable, clockRun, bootRomSelect, flashWriteGo, flashWriteEnabled;
    logic [1:0] eepromMode;
    logic [7:0] irqLines, ioRdata;
    logic [2:0] ledIn, ledOut;
    io_req_t    ioReq;
    int         numErrors = 0;
    int         compares = 0;

    nic_power_and_pnp_port_regs #(.GROUP_BASE(BASE)) u_nic_power_and_pnp_port_regs (
        .clk_sys(clk_sys), .rst(rst), .ioReq(ioReq), .eepromMode(eepromMode),
        .eepromPowerDown(eepromPowerDown), .eepromFullDecode(eepromFullDecode), .irqLines(irqLines),
        .ledIn(ledIn), .coaxLedIn(coaxLedIn), .bootRomReadReq(bootRomReadReq), .flashWriteReq(flashWriteReq),
        .ioRdata(ioRdata), .ioRdataValid(ioRdataValid), .ledOut(ledOut), .coaxLed(coaxLed),
        .netEnable(netEnable), .clockRun(clockRun), .bootRomSelect(bootRomSelect),
        .flashWriteGo(flashWriteGo), .flashWriteEnabled(flashWriteEnabled));

    isa_host_model #(.GROUP_BASE(BASE)) u_isa_host_model (
        .clk_sys(clk_sys), .ioReq(ioReq), .ioRdata(ioRdata), .ioRdataValid(ioRdataValid));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdChk(input logic [15:0] a, input logic expV, input logic [7:0] expD);
        logic [7:0] d;
        logic       v;
        u_isa_host_model.ioRead(a, d, v);
        chk("ioRdataValid", {7'h00, expV}, {7'h00, v});
        if (expV) chk("ioRdata", expD, d);
    endtask : rdChk

    task automatic pnpRead(input logic [7:0] idx, input logic [7:0] expD);
        u_isa_host_model.ioWrite({4'h0, `PORT_PNP_INDEX}, idx);
        rdChk(RPORT, 1'b1, expD);
        rdChk(RPORT, 1'b1, expD);
    endtask : pnpRead

    task automatic grpWrite(input logic [3:0] off, input logic [7:0] d);
        u_isa_host_model.ioWrite(BASE + {12'h000, off}, d);
        repeat (3) @(negedge clk_sys);
    endtask : grpWrite

    task automatic outChk(input logic [2:0] led, input logic cx, input logic net, input logic clk);
        chk("ledOut", {5'h00, led}, {5'h00, ledOut});
        chk("coaxLed", {7'h00, cx}, {7'h00, coaxLed});
        chk("netEnable", {7'h00, net}, {7'h00, netEnable});
        chk("clockRun", {7'h00, clk}, {7'h00, clockRun});
    endtask : outChk

    task automatic flashTry(input logic exp);
        logic got;
        @(negedge clk_sys);
        flashWriteReq = 1'b1;
        @(negedge clk_sys);
        flashWriteReq = 1'b0;
        got = flashWriteGo;
        @(negedge clk_sys);
        got = got | flashWriteGo;
        chk("flashWriteGo", {7'h00, exp}, {7'h00, got});
    endtask : flashTry

    task automatic scnInactive();
        outChk(3'b010, 1'b1, 1'b1, 1'b1);
        rdChk(BASE + 16'h000b, 1'b0, 8'h00);
        chk("bootRomSelect", 8'h00, {7'h00, bootRomSelect});
    endtask : scnInactive

    task automatic scnPnp();
        u_isa_host_model.sendKey();
        u_isa_host_model.pnpWrite(`IDX_CARD_SELECT, 8'h05);
        u_isa_host_model.pnpWrite(`IDX_SET_READ_PORT, 8'h80);
        pnpRead(`IDX_CARD_SELECT, 8'h05);
        pnpRead(8'h07, 8'h00);
        u_isa_host_model.pnpWrite(`IDX_ACTIVATE, 8'h01);
        pnpRead(`IDX_ACTIVATE, 8'h01);
        chk("bootRomSelect", 8'h01, {7'h00, bootRomSelect});
    endtask : scnPnp

    task automatic scnGroup();
        rdChk(BASE + 16'h0008, 1'b1, 8'h05);
        rdChk(BASE + 16'h000b, 1'b1, 8'ha5);
        irqLines = 8'h3c;
        rdChk(BASE + 16'h000b, 1'b1, 8'h3c);
        rdChk(BASE + 16'hf00b, 1'b1, 8'h3c);
        rdChk(BASE + 16'h000d, 1'b1, 8'h00);
        rdChk(BASE + 16'h0006, 1'b1, 8'h00);
        rdChk(BASE + 16'h000f, 1'b0, 8'h00);
    endtask : scnGroup

    task automatic scnSleep();
        grpWrite(`OFF_POWER_LED_CONFIG, 8'h04);
        rdChk(BASE + 16'h0006, 1'b1, 8'h00);
        eepromMode = 2'b11;
        grpWrite(`OFF_POWER_LED_CONFIG, 8'h04);
        rdChk(BASE + 16'h0006, 1'b1, 8'h04);
        outChk(3'b111, 1'b1, 1'b1, 1'b1);
        grpWrite(`OFF_POWER_LED_CONFIG, 8'h00);
        outChk(3'b010, 1'b1, 1'b1, 1'b1);
    endtask : scnSleep

    task automatic scnPower();
        grpWrite(`OFF_CLOCK_HALT, `HALT_CMD_HALTED);
        outChk(3'b010, 1'b1, 1'b1, 1'b1);
        grpWrite(`OFF_POWER_LED_CONFIG, 8'h02);
        rdChk(BASE + 16'h0006, 1'b1, 8'h02);
        outChk(3'b111, 1'b0, 1'b0, 1'b1);
        grpWrite(`OFF_CLOCK_HALT, 8'h33);
        chk("clockRun", 8'h01, {7'h00, clockRun});
        grpWrite(`OFF_CLOCK_HALT, `HALT_CMD_HALTED);
        outChk(3'b111, 1'b0, 1'b0, 1'b0);
        rdChk(BASE + 16'h000b, 1'b0, 8'h00);
        grpWrite(`OFF_CLOCK_HALT, `HALT_CMD_RUNNING);
        chk("clockRun", 8'h01, {7'h00, clockRun});
        grpWrite(`OFF_POWER_LED_CONFIG, 8'h00);
        outChk(3'b010, 1'b1, 1'b1, 1'b1);
    endtask : scnPower

    task automatic scnFlash();
        flashTry(1'b0);
        u_isa_host_model.unlockFlash();
        @(negedge clk_sys);
        chk("flashWriteEnabled", 8'h01, {7'h00, flashWriteEnabled});
        flashTry(1'b1);
        grpWrite(`OFF_FLASH_UNLOCK, 8'h33);
        chk("flashWriteEnabled", 8'h00, {7'h00, flashWriteEnabled});
        eepromMode = 2'b00;
        u_isa_host_model.unlockFlash();
        chk("flashWriteEnabled", 8'h00, {7'h00, flashWriteEnabled});
        flashTry(1'b0);
    endtask : scnFlash

    // Second reset with both straps set: power-down from the strap, full decode, halt while inactive.
    task automatic scnStraps();
        rst = 1'b1;
        eepromPowerDown = 1'b1;
        eepromFullDecode = 1'b1;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        outChk(3'b111, 1'b0, 1'b0, 1'b1);
        grpWrite(`OFF_CLOCK_HALT, `HALT_CMD_HALTED);
        chk("clockRun", 8'h00, {7'h00, clockRun});
        grpWrite(`OFF_CLOCK_HALT, `HALT_CMD_RUNNING);
        chk("clockRun", 8'h01, {7'h00, clockRun});
        u_isa_host_model.sendKey();
        u_isa_host_model.pnpWrite(`IDX_ACTIVATE, 8'h01);
        rdChk(BASE + 16'h000d, 1'b1, 8'h01);
        rdChk(BASE + 16'h0006, 1'b1, 8'h02);
        rdChk(BASE + 16'hf00d, 1'b0, 8'h00);
    endtask : scnStraps

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1;
        eepromMode = 2'b00;
        eepromPowerDown = 1'b0;
        eepromFullDecode = 1'b0;
        irqLines = 8'ha5;
        ledIn = 3'b010;
        coaxLedIn = 1'b1;
        bootRomReadReq = 1'b1;
        flashWriteReq = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        scnInactive();
        scnPnp();
        scnGroup();
        scnSleep();
        scnPower();
        scnFlash();
        scnStraps();
        conclude();
    end
endmodule : nic_power_and_pnp_port_regs_tb
